// [hw/mpcs_pkg.sv]
// Package: constants and carrier types of the MAC path control/status block
package mpcs_pkg;

  // ---------------------------------------------------------------
  // Framing constants
  // ---------------------------------------------------------------
  localparam int BEAT_BYTES = 8;
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam logic [55:0] STD_PREAMBLE = 56'hD5555555555555;
  localparam logic [15:0] MIN_LEGAL_LEN = 16'h0040;
  localparam logic [3:0] FCS_BYTES = 4'h4;
  localparam logic [15:0] NOSTRIP_MAX_LEN = 16'h0008;
  localparam int MAX_LEN_W = 15;
  localparam int MIN_LEN_W = 8;
  localparam int CNT_W = 16;

  // ---------------------------------------------------------------
  // Fault sequencing constants
  // ---------------------------------------------------------------
  localparam logic [2:0] FLT_SEQ_MAX = 3'h4;
  localparam logic [7:0] FLT_COL_MAX = 8'h7F;
  localparam logic [1:0] FLT_LOCAL = 2'h1;
  localparam logic [1:0] FLT_REMOTE = 2'h2;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic sop;
    logic last;
    logic [63:0] data;
    logic [7:0] keep;
    logic fcs_bad;
    logic fcs_stomped;
  } mpcs_line_t;

  typedef struct packed {
    logic tvalid;
    logic [63:0] tdata;
    logic [7:0] tkeep;
    logic tlast;
    logic tuser;
  } mpcs_axis_t;

  typedef enum logic {TX_INIT, TX_RUN} mpcs_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_PKT, RX_DROP} mpcs_rx_state_t;

endpackage

// [hw/mpcs_path_ctrl.sv]
// MAC/PCS transmit and receive path control and status logic
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// RULE1 - No FCS insertion and TX ignore-FCS high: bad-FCS packet counts good, still flagged
// RULE2 - TX local fault is high exactly while the TX machine is in init
// RULE3 - TX custom preamble mode takes preamble from the sideband input
// RULE4 - RX disable finishes current packet, then no decode, stats or stream output
// RULE5 - Check-preamble and check-SFD controls verify the received preamble and SFD
// RULE6 - Force-resync pulse resets and resynchronises the RX path
// RULE7 - FCS removal strips FCS except packets of 8 bytes or fewer
// RULE8 - RX ignore-FCS low flags FCS error on last beat; high treats good
// RULE9 - Packets reaching max length before their last beat truncate with error; under 64 bytes are bad
// RULE10 - Packets under min length flag error on end-of-packet beat
// RULE11 - Two-bit sync header error count valid only with its strobe
// RULE12 - RX local fault equals internal OR received local fault
// RULE13 - Block lock output is high while block lock is achieved
// RULE14 - Remote fault output high while remote fault condition detected
// RULE15 - Bad-FCS and stomped-FCS counts pulse one cycle, back to back allowed
// RULE16 - Truncation status pulses one cycle per cut packet
// RULE17 - Internal local fault high while test pattern or high error rate lasts
// RULE18 - Received local fault high once enough LF ordered sets arrive
// RULE19 - Error rate high output follows the high error rate condition
// RULE20 - RX custom preamble mode presents the line preamble on the sideband
// RULE21 - Local loopback input enables PCS loopback, changed only in reset; the code copies i_local_loopback to o_loopback on every enabled cycle
// RULE22 - LF processing control selects whether LF codes are processed
module mpcs_path_ctrl (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_tx_sop,
  input wire logic i_tx_eop,
  input wire logic i_tx_user,
  input wire logic i_tx_fcs_bad,
  input wire logic i_tx_fcs_ins_enable,
  input wire logic i_tx_ignore_fcs,
  input wire logic i_tx_custom_preamble_enable,
  input wire logic [55:0] i_tx_preamble,
  input wire mpcs_pkg::mpcs_line_t i_rx_line,
  input wire logic [55:0] i_rx_line_preamble,
  input wire logic i_rx_enable,
  input wire logic i_rx_check_preamble,
  input wire logic i_rx_check_sfd,
  input wire logic i_rx_force_resync,
  input wire logic i_rx_delete_fcs,
  input wire logic i_rx_ignore_fcs,
  input wire logic [mpcs_pkg::MAX_LEN_W-1:0] i_rx_max_packet_len,
  input wire logic [mpcs_pkg::MIN_LEN_W-1:0] i_rx_min_packet_len,
  input wire logic i_rx_custom_preamble_enable,
  input wire logic i_rx_lock_raw,
  input wire logic i_rx_ber_high,
  input wire logic i_rx_test_pattern,
  input wire logic [1:0] i_rx_sh_err,
  input wire logic i_rx_sh_err_valid,
  input wire logic i_rx_col,
  input wire logic i_rx_os_lf,
  input wire logic i_rx_os_rf,
  input wire logic i_rx_process_lfi,
  input wire logic i_local_loopback,
  output mpcs_pkg::mpcs_axis_t o_rx_axis,
  output logic [55:0] o_tx_preamble,
  output logic o_tx_good_pkt,
  output logic o_tx_bad_fcs,
  output logic o_tx_local_fault,
  output logic [55:0] o_rx_preamble,
  output logic o_rx_good_pkt,
  output logic o_rx_small_pkt,
  output logic o_rx_bad_preamble,
  output logic o_rx_bad_sfd,
  output logic [2:0] o_rx_bad_fcs,
  output logic [2:0] o_rx_stomped_fcs,
  output logic o_rx_truncated,
  output logic [1:0] o_rx_framing_err,
  output logic o_rx_framing_err_valid,
  output logic o_rx_local_fault,
  output logic o_rx_internal_local_fault,
  output logic o_rx_received_local_fault,
  output logic o_rx_remote_fault,
  output logic o_rx_block_lock,
  output logic o_rx_error_rate_high,
  output logic o_loopback
);
  import mpcs_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] nbytes(input logic [7:0] keep);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < BEAT_BYTES; i++) begin
      n = n + {3'h0, keep[i]};
    end
    return n;
  endfunction
  function automatic logic [7:0] keep_of(input logic [3:0] n);
    logic [8:0] m;
    m = (9'h001 << n) - 9'h001;
    return m[7:0];
  endfunction
  // ---------------------------------------------------------------
  // Transmit path
  // ---------------------------------------------------------------
  mpcs_tx_state_t tx_state_q, tx_state_d;
  // Init is left only once the receiver is locked and free of local fault
  always_comb begin
    tx_state_d = tx_state_q;
    case (tx_state_q)
      TX_INIT: if (o_rx_block_lock && !o_rx_local_fault) tx_state_d = TX_RUN;
      TX_RUN: if (!o_rx_block_lock) tx_state_d = TX_INIT;
      default: tx_state_d = TX_INIT;
    endcase
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_state_q <= TX_INIT;
      o_tx_local_fault <= 1'b1;
    end else if (i_ce) begin
      tx_state_q <= tx_state_d;
      o_tx_local_fault <= (tx_state_d == TX_INIT); // RULE2
    end
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_tx_preamble <= STD_PREAMBLE;
      o_tx_good_pkt <= 1'b0;
      o_tx_bad_fcs <= 1'b0;
    end else if (i_ce) begin
      if (i_tx_sop) begin
        o_tx_preamble <= i_tx_custom_preamble_enable ? i_tx_preamble : STD_PREAMBLE; // RULE3
      end
      // With insertion on, the core's own FCS replaces any client value
      o_tx_good_pkt <= i_tx_eop && !i_tx_user &&
                       (i_tx_fcs_ins_enable || !i_tx_fcs_bad || i_tx_ignore_fcs); // RULE1
      o_tx_bad_fcs <= i_tx_eop && !i_tx_fcs_ins_enable && i_tx_fcs_bad; // RULE1
    end
  end

  // ---------------------------------------------------------------
  // Receive packet checks and truncation
  // ---------------------------------------------------------------
  mpcs_rx_state_t rx_state_q, rx_state_d;
  mpcs_axis_t p, h_q, h_d, o_d;
  logic [CNT_W-1:0] cnt_q, base, len_sum, max_len;
  logic [3:0] nb;
  logic err_q, err_d, take, cut, fin, pre_bad, sfd_bad, fcs_err, strip;
  assign nb = nbytes(i_rx_line.keep);
  assign base = i_rx_line.sop ? '0 : cnt_q;
  assign len_sum = base + {12'h000, nb};
  // Top bit of the setting is reserved and ignored
  assign max_len = {2'b00, i_rx_max_packet_len[MAX_LEN_W-2:0]};
  assign pre_bad = i_rx_check_preamble &&
                   (i_rx_line_preamble[47:0] != {6{PRE_BYTE}}); // RULE5
  assign sfd_bad = i_rx_check_sfd && (i_rx_line_preamble[55:48] != SFD_BYTE); // RULE5
  assign fcs_err = (i_rx_line.fcs_bad || i_rx_line.fcs_stomped) && !i_rx_ignore_fcs; // RULE8
  always_comb begin
    rx_state_d = rx_state_q;
    take = 1'b0;
    case (rx_state_q)
      RX_IDLE: begin
        if (i_rx_line.valid && i_rx_line.sop) begin
          take = i_rx_enable; // RULE4
          if (!i_rx_enable && !i_rx_line.last) rx_state_d = RX_DROP;
        end
      end
      RX_PKT: take = i_rx_line.valid;
      RX_DROP: if (i_rx_line.valid && i_rx_line.last) rx_state_d = RX_IDLE;
      default: rx_state_d = RX_IDLE;
    endcase
    cut = take && !i_rx_line.last && (len_sum >= max_len); // RULE9
    fin = take && i_rx_line.last;
    err_d = (i_rx_line.sop ? 1'b0 : err_q) || (i_rx_line.sop && (pre_bad || sfd_bad));
    p = '0;
    p.tvalid = take;
    p.tdata = i_rx_line.data;
    p.tkeep = i_rx_line.keep;
    p.tlast = fin;
    if (cut) begin
      p.tkeep = keep_of(4'(max_len - base)); // RULE9
      p.tlast = 1'b1;
      p.tuser = 1'b1; // RULE9
      rx_state_d = RX_DROP;
    end else if (fin) begin
      p.tuser = err_d || fcs_err || (len_sum < MIN_LEGAL_LEN) ||
                (len_sum < {8'h00, i_rx_min_packet_len}); // RULE10
      rx_state_d = RX_IDLE;
    end else if (take) begin
      rx_state_d = RX_PKT;
    end
  end

  // ---------------------------------------------------------------
  // FCS strip through a one-beat holding stage
  // ---------------------------------------------------------------
  // The hold lets a short last beat shorten the beat before it
  assign strip = fin && i_rx_delete_fcs && (len_sum > NOSTRIP_MAX_LEN); // RULE7
  always_comb begin
    o_d = '0;
    h_d = h_q;
    if (p.tvalid) begin
      o_d = h_q;
      h_d = p;
      if (strip && nb <= FCS_BYTES) begin
        o_d.tkeep = h_q.tkeep >> (FCS_BYTES - nb); // RULE7
        o_d.tlast = 1'b1;
        o_d.tuser = p.tuser;
        h_d = '0;
      end else if (strip) begin
        h_d.tkeep = p.tkeep >> FCS_BYTES; // RULE7
      end
    end else if (h_q.tvalid && h_q.tlast) begin
      o_d = h_q;
      h_d = '0;
    end
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_state_q <= RX_IDLE;
      cnt_q <= '0;
      err_q <= 1'b0;
      h_q <= '0;
      o_rx_axis <= '0;
    end else if (i_ce) begin
      // Resync empties the path at once; the next sop restarts length and error tracking
      rx_state_q <= i_rx_force_resync ? RX_IDLE : rx_state_d; // RULE6
      if (take && !i_rx_force_resync) begin
        cnt_q <= len_sum;
        err_q <= err_d;
      end
      h_q <= i_rx_force_resync ? '0 : h_d; // RULE6
      o_rx_axis <= i_rx_force_resync ? '0 : o_d; // RULE6
    end
  end

  // ---------------------------------------------------------------
  // Receive statistics
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rx_preamble <= '0;
      o_rx_good_pkt <= 1'b0;
      o_rx_small_pkt <= 1'b0;
      o_rx_bad_preamble <= 1'b0;
      o_rx_bad_sfd <= 1'b0;
      o_rx_bad_fcs <= 3'h0;
      o_rx_stomped_fcs <= 3'h0;
      o_rx_truncated <= 1'b0;
    end else if (i_ce) begin
      if (take && i_rx_line.sop) begin
        o_rx_preamble <= i_rx_custom_preamble_enable ? i_rx_line_preamble : '0; // RULE20
      end
      o_rx_bad_preamble <= take && i_rx_line.sop && pre_bad; // RULE5
      o_rx_bad_sfd <= take && i_rx_line.sop && sfd_bad; // RULE5
      o_rx_good_pkt <= fin && !p.tuser; // RULE8
      o_rx_small_pkt <= fin && (len_sum < MIN_LEGAL_LEN); // RULE9
      o_rx_bad_fcs <= {2'b00, fin && i_rx_line.fcs_bad && !i_rx_line.fcs_stomped}; // RULE15
      o_rx_stomped_fcs <= {2'b00, fin && i_rx_line.fcs_stomped}; // RULE15
      o_rx_truncated <= cut; // RULE16
    end
  end

  // ---------------------------------------------------------------
  // Link status and fault sequencing
  // ---------------------------------------------------------------
  logic [1:0] os_type_q, os_type_d, flt_q, flt_d;
  logic [2:0] seq_q, seq_d;
  logic [7:0] col_q, col_d;
  logic lf_seen, int_lf_d;
  // LF sets are dropped entirely when processing is off
  assign lf_seen = i_rx_os_lf && i_rx_process_lfi; // RULE22
  assign int_lf_d = i_rx_test_pattern || i_rx_ber_high; // RULE17
  always_comb begin
    os_type_d = os_type_q;
    seq_d = seq_q;
    col_d = col_q;
    flt_d = flt_q;
    if (i_rx_col) begin
      if (lf_seen || i_rx_os_rf) begin
        os_type_d = i_rx_os_rf ? FLT_REMOTE : FLT_LOCAL;
        col_d = 8'h00;
        if (os_type_d != os_type_q) begin
          seq_d = 3'h1;
        end else if (seq_q < FLT_SEQ_MAX) begin
          seq_d = seq_q + 3'h1;
        end
        if (seq_d == FLT_SEQ_MAX) flt_d = os_type_d; // RULE18
      end else if (col_q == FLT_COL_MAX) begin
        seq_d = 3'h0;
        os_type_d = 2'h0;
        flt_d = 2'h0;
        col_d = 8'h00;
      end else begin
        col_d = col_q + 8'h01;
      end
    end
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      os_type_q <= 2'h0;
      seq_q <= 3'h0;
      col_q <= 8'h00;
      flt_q <= 2'h0;
      o_rx_received_local_fault <= 1'b0;
      o_rx_remote_fault <= 1'b0;
      o_rx_internal_local_fault <= 1'b0;
      o_rx_local_fault <= 1'b0;
    end else if (i_ce) begin
      os_type_q <= os_type_d;
      seq_q <= seq_d;
      col_q <= col_d;
      flt_q <= flt_d;
      o_rx_received_local_fault <= (flt_d == FLT_LOCAL); // RULE18
      o_rx_remote_fault <= (flt_d == FLT_REMOTE); // RULE14
      o_rx_internal_local_fault <= int_lf_d; // RULE17
      o_rx_local_fault <= int_lf_d || (flt_d == FLT_LOCAL); // RULE12
    end
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rx_block_lock <= 1'b0;
      o_rx_error_rate_high <= 1'b0;
      o_rx_framing_err <= 2'h0;
      o_rx_framing_err_valid <= 1'b0;
      o_loopback <= 1'b0;
    end else if (i_ce) begin
      // Lock is dropped for the resync cycle so it is re-acquired
      o_rx_block_lock <= i_rx_lock_raw && !i_rx_force_resync; // RULE13
      o_rx_error_rate_high <= i_rx_ber_high; // RULE19
      o_rx_framing_err <= i_rx_sh_err_valid ? i_rx_sh_err : 2'h0; // RULE11
      o_rx_framing_err_valid <= i_rx_sh_err_valid; // RULE11
      o_loopback <= i_local_loopback; // RULE21
    end
  end
  // ---------------------------------------------------------------
  // Assertions (they assume i_ce held high)
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset || !i_ce);
  a_tx_init_fault: assert property ( // RULE2
    !o_rx_block_lock |=> o_tx_local_fault && tx_state_q == TX_INIT) else $error("tx init lost");
  a_tx_ignore_fcs: assert property ( // RULE1
    i_tx_eop && !i_tx_fcs_ins_enable && i_tx_fcs_bad && !i_tx_user |=>
    o_tx_bad_fcs && (o_tx_good_pkt == $past(i_tx_ignore_fcs))) else $error("tx fcs binning");
  a_tx_custom_pre: assert property ( // RULE3
    i_tx_sop && i_tx_custom_preamble_enable |=> o_tx_preamble == $past(i_tx_preamble))
    else $error("tx preamble not sideband");
  a_rx_off_idle: assert property ( // RULE4
    rx_state_q != RX_PKT && !h_q.tvalid && !i_rx_enable |=> !o_rx_axis.tvalid)
    else $error("rx stream active while disabled");
  a_resync_clear: assert property ( // RULE6
    i_rx_force_resync |=> !o_rx_block_lock && rx_state_q == RX_IDLE && !o_rx_axis.tvalid)
    else $error("resync did not clear rx");
  a_fcs_err_last: assert property ( // RULE8
    fin && i_rx_line.fcs_bad && !i_rx_ignore_fcs |=> ##[0:1] o_rx_axis.tlast && o_rx_axis.tuser)
    else $error("fcs error not on last beat");
  a_trunc_end: assert property ( // RULE16
    o_rx_truncated |=> o_rx_axis.tvalid && o_rx_axis.tlast && o_rx_axis.tuser)
    else $error("truncated packet end missing");
  a_lf_or: assert property ( // RULE12
    o_rx_local_fault == (o_rx_internal_local_fault || o_rx_received_local_fault))
    else $error("local fault not or");
  a_ber_follow: assert property ( // RULE19
    ##1 o_rx_error_rate_high == $past(i_rx_ber_high)) else $error("error rate high lags");
endmodule
`default_nettype wire

// [verification/mpcs_client_model.sv]
// Client-side model that takes every beat of the receive stream
`timescale 1ns/100ps
`default_nettype none
module mpcs_client_model (
  input wire logic i_clk,
  input wire logic i_clr,
  input wire mpcs_pkg::mpcs_axis_t i_axis,
  output logic [15:0] o_beats,
  output logic [7:0] o_last_keep,
  output logic o_last_user,
  output logic [7:0] o_lasts,
  output logic [63:0] o_last_data
);
  import mpcs_pkg::*;
  // ----
  // Collector
  // ----
  // No backpressure exists, so the client must take a beat every cycle
  always @(posedge i_clk) begin
    if (i_clr) begin
      o_beats <= 16'h0000;
      o_lasts <= 8'h00;
      o_last_keep <= 8'h00;
      o_last_user <= 1'b0;
      o_last_data <= 64'h0;
    end else if (i_axis.tvalid) begin
      o_beats <= o_beats + 16'h0001;
      if (i_axis.tlast) begin
        o_lasts <= o_lasts + 8'h01;
        o_last_keep <= i_axis.tkeep;
        o_last_user <= i_axis.tuser;
        o_last_data <= i_axis.tdata;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the MAC path control and status block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import mpcs_pkg::*;
  // ----
  // Signals
  // ----
  logic i_clk = 1'b0, i_reset = 1'b1, i_ce = 1'b1;
  logic i_tx_sop = 1'b0, i_tx_eop = 1'b0, i_tx_user = 1'b0, i_tx_fcs_bad = 1'b0;
  logic i_tx_fcs_ins_enable = 1'b0, i_tx_ignore_fcs = 1'b0;
  logic i_tx_custom_preamble_enable = 1'b0;
  logic [55:0] i_tx_preamble = 56'h0, i_rx_line_preamble = STD_PREAMBLE;
  mpcs_line_t i_rx_line = '0;
  logic i_rx_enable = 1'b1, i_rx_check_preamble = 1'b0, i_rx_check_sfd = 1'b0;
  logic i_rx_force_resync = 1'b0, i_rx_delete_fcs = 1'b0, i_rx_ignore_fcs = 1'b0;
  logic [14:0] i_rx_max_packet_len = 15'h2580;
  logic [7:0] i_rx_min_packet_len = 8'h40;
  logic i_rx_custom_preamble_enable = 1'b0, i_rx_lock_raw = 1'b0, i_rx_ber_high = 1'b0;
  logic i_rx_test_pattern = 1'b0, i_rx_sh_err_valid = 1'b0, i_rx_col = 1'b0;
  logic [1:0] i_rx_sh_err = 2'h0;
  logic i_rx_os_lf = 1'b0, i_rx_os_rf = 1'b0, i_rx_process_lfi = 1'b0;
  logic i_local_loopback = 1'b1;
  mpcs_axis_t o_rx_axis;
  logic [55:0] o_tx_preamble, o_rx_preamble;
  logic [2:0] o_rx_bad_fcs, o_rx_stomped_fcs;
  logic [1:0] o_rx_framing_err;
  logic o_tx_good_pkt, o_tx_bad_fcs, o_tx_local_fault, o_rx_good_pkt, o_rx_small_pkt;
  logic o_rx_bad_preamble, o_rx_bad_sfd, o_rx_truncated, o_rx_framing_err_valid;
  logic o_rx_local_fault, o_rx_internal_local_fault, o_rx_received_local_fault;
  logic o_rx_remote_fault, o_rx_block_lock, o_rx_error_rate_high, o_loopback;
  logic ln_clr = 1'b1, m_user;
  logic [15:0] m_beats;
  logic [7:0] m_keep, m_lasts;
  logic [63:0] m_data;
  int num_errors = 0, checks = 0, cyc = 0;
  int n_good, n_bfcs, n_stomp, n_small, n_trunc, n_bpre, n_bsfd;

  mpcs_path_ctrl mpcs_path_ctrl_i (
    .i_clk, .i_reset, .i_ce, .i_tx_sop, .i_tx_eop, .i_tx_user, .i_tx_fcs_bad,
    .i_tx_fcs_ins_enable, .i_tx_ignore_fcs, .i_tx_custom_preamble_enable,
    .i_tx_preamble, .i_rx_line, .i_rx_line_preamble, .i_rx_enable,
    .i_rx_check_preamble, .i_rx_check_sfd, .i_rx_force_resync, .i_rx_delete_fcs,
    .i_rx_ignore_fcs, .i_rx_max_packet_len, .i_rx_min_packet_len,
    .i_rx_custom_preamble_enable, .i_rx_lock_raw, .i_rx_ber_high, .i_rx_test_pattern,
    .i_rx_sh_err, .i_rx_sh_err_valid, .i_rx_col, .i_rx_os_lf, .i_rx_os_rf,
    .i_rx_process_lfi, .i_local_loopback, .o_rx_axis, .o_tx_preamble, .o_tx_good_pkt,
    .o_tx_bad_fcs, .o_tx_local_fault, .o_rx_preamble, .o_rx_good_pkt, .o_rx_small_pkt,
    .o_rx_bad_preamble, .o_rx_bad_sfd, .o_rx_bad_fcs, .o_rx_stomped_fcs,
    .o_rx_truncated, .o_rx_framing_err, .o_rx_framing_err_valid, .o_rx_local_fault,
    .o_rx_internal_local_fault, .o_rx_received_local_fault, .o_rx_remote_fault,
    .o_rx_block_lock, .o_rx_error_rate_high, .o_loopback
  );

  mpcs_client_model mpcs_client_model_i (
    .i_clk(i_clk), .i_clr(ln_clr), .i_axis(o_rx_axis), .o_beats(m_beats),
    .o_last_keep(m_keep), .o_last_user(m_user), .o_lasts(m_lasts), .o_last_data(m_data)
  );

  always #25 i_clk = ~i_clk;

  // ----
  // Shared tasks
  // ----
  task automatic final_report();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // Stats are pulses, so they are summed per packet rather than sampled once
  always @(posedge i_clk) begin
    cyc++;
    n_good += int'(o_rx_good_pkt);
    n_bfcs += int'(o_rx_bad_fcs);
    n_stomp += int'(o_rx_stomped_fcs);
    n_small += int'(o_rx_small_pkt);
    n_trunc += int'(o_rx_truncated);
    n_bpre += int'(o_rx_bad_preamble);
    n_bsfd += int'(o_rx_bad_sfd);
    if (cyc == 3000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic pkt(input int nb, input logic [7:0] lk, input logic bad, input logic stp);
    {n_good, n_bfcs, n_stomp, n_small, n_trunc, n_bpre, n_bsfd} = '0;
    ln_clr = 1'b1;
    @(negedge i_clk);
    ln_clr = 1'b0;
    for (int i = 0; i < nb; i++) begin
      i_rx_line.valid = 1'b1;
      i_rx_line.sop = (i == 0);
      i_rx_line.last = (i == nb - 1);
      i_rx_line.keep = (i == nb - 1) ? lk : 8'hFF;
      i_rx_line.data = 64'(i);
      i_rx_line.fcs_bad = bad;
      i_rx_line.fcs_stomped = stp;
      @(negedge i_clk);
    end
    i_rx_line = '0;
    repeat (4) @(negedge i_clk);
  endtask

  task automatic pchk(input int nb, input logic [7:0] lk, input logic us);
    chk(m_beats, nb, "beats");
    chk(m_lasts, 1, "lasts");
    chk(m_keep, lk, "last keep");
    chk(m_user, us, "tuser");
  endtask

  task automatic cols(input int n, input logic lf, input logic rf);
    repeat (n) begin
      i_rx_col = 1'b1;
      i_rx_os_lf = lf;
      i_rx_os_rf = rf;
      @(negedge i_clk);
    end
    {i_rx_col, i_rx_os_lf, i_rx_os_rf} = 3'h0;
    repeat (2) @(negedge i_clk);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_lock();
    chk(o_loopback, 1, "loopback");
    chk(o_tx_local_fault, 1, "tx init");
    i_rx_lock_raw = 1'b1;
    repeat (3) @(negedge i_clk);
    chk(o_rx_block_lock, 1, "lock");
    chk(o_tx_local_fault, 0, "tx run");
  endtask

  task automatic t_tx();
    i_tx_eop = 1'b1;
    i_tx_fcs_bad = 1'b1;
    for (int k = 0; k < 2; k++) begin
      i_tx_ignore_fcs = (k == 0);
      @(negedge i_clk);
      chk(o_tx_good_pkt, k == 0, "tx good");
      chk(o_tx_bad_fcs, 1, "tx bad fcs");
    end
    i_tx_eop = 1'b0;
    i_tx_sop = 1'b1;
    i_tx_custom_preamble_enable = 1'b1;
    i_tx_preamble = 56'h0123456789ABCD;
    @(negedge i_clk);
    chk(o_tx_preamble, 56'h0123456789ABCD, "custom pre");
    i_tx_custom_preamble_enable = 1'b0;
    @(negedge i_clk);
    chk(o_tx_preamble, STD_PREAMBLE, "std pre");
    i_tx_sop = 1'b0;
  endtask

  task automatic t_fcs();
    pkt(8, 8'hFF, 1'b0, 1'b0);
    pchk(8, 8'hFF, 1'b0);
    chk(n_good, 1, "good");
    chk(m_data, 7, "last data");
    pkt(8, 8'hFF, 1'b1, 1'b0);
    pchk(8, 8'hFF, 1'b1);
    chk(n_bfcs, 1, "bad fcs");
    i_rx_ignore_fcs = 1'b1;
    pkt(8, 8'hFF, 1'b1, 1'b0);
    pchk(8, 8'hFF, 1'b0);
    chk(n_bfcs, 1, "bad fcs ign");
    chk(n_good, 1, "good ign");
    i_rx_ignore_fcs = 1'b0;
    pkt(9, 8'h0F, 1'b0, 1'b1);
    pchk(9, 8'h0F, 1'b1);
    chk(n_stomp, 1, "stomped");
    chk(n_bfcs, 0, "stomp not bad");
  endtask

  task automatic t_len();
    i_rx_min_packet_len = 8'h50;
    pkt(9, 8'hFF, 1'b0, 1'b0);
    pchk(9, 8'hFF, 1'b1);
    i_rx_min_packet_len = 8'h40;
    i_rx_max_packet_len = 15'h0040;
    pkt(8, 8'hFF, 1'b0, 1'b0);
    pchk(8, 8'hFF, 1'b0);
    chk(n_trunc, 0, "no cut");
    pkt(10, 8'hFF, 1'b0, 1'b0);
    pchk(8, 8'hFF, 1'b1);
    chk(n_trunc, 1, "cut");
    pkt(1, 8'h0F, 1'b0, 1'b0);
    pchk(1, 8'h0F, 1'b1);
    chk(n_small, 1, "small");
    i_rx_max_packet_len = 15'h2580;
  endtask

  task automatic t_pre();
    i_rx_custom_preamble_enable = 1'b1;
    i_rx_check_preamble = 1'b1;
    i_rx_line_preamble = 56'hD5555555555554;
    pkt(8, 8'hFF, 1'b0, 1'b0);
    pchk(8, 8'hFF, 1'b1);
    chk(n_bpre, 1, "bad pre");
    chk(o_rx_preamble, 56'hD5555555555554, "rx pre");
    i_rx_check_preamble = 1'b0;
    i_rx_check_sfd = 1'b1;
    pkt(8, 8'hFF, 1'b0, 1'b0);
    pchk(8, 8'hFF, 1'b0);
    i_rx_line_preamble = 56'hD4555555555555;
    pkt(8, 8'hFF, 1'b0, 1'b0);
    pchk(8, 8'hFF, 1'b1);
    chk(n_bsfd, 1, "bad sfd");
    chk(o_rx_preamble, 56'hD4555555555555, "rx pre");
    {i_rx_check_sfd, i_rx_custom_preamble_enable} = 2'h0;
    i_rx_line_preamble = STD_PREAMBLE;
    pkt(8, 8'hFF, 1'b0, 1'b0);
    chk(o_rx_preamble, 0, "no custom pre");
  endtask

  task automatic t_dis();
    i_rx_enable = 1'b0;
    pkt(8, 8'hFF, 1'b0, 1'b0);
    chk(m_beats, 0, "idle stream");
    chk(n_good, 0, "no stats");
    i_rx_enable = 1'b1;
  endtask

  task automatic strip_rst(input logic d);
    i_reset = 1'b1;
    i_rx_delete_fcs = d;
    @(negedge i_clk);
    i_reset = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask

  task automatic t_strip();
    strip_rst(1'b1);
    pkt(9, 8'hFF, 1'b0, 1'b0);
    pchk(9, 8'h0F, 1'b0);
    pkt(9, 8'h0F, 1'b0, 1'b0);
    pchk(8, 8'hFF, 1'b0);
    chk(m_data, 7, "strip data");
    pkt(1, 8'hFF, 1'b0, 1'b0);
    pchk(1, 8'hFF, 1'b1);
    strip_rst(1'b0);
  endtask

  task automatic t_sh();
    i_rx_sh_err = 2'h3;
    i_rx_sh_err_valid = 1'b1;
    @(negedge i_clk);
    chk(o_rx_framing_err, 2'h3, "sh count");
    chk(o_rx_framing_err_valid, 1, "sh valid");
    i_rx_sh_err_valid = 1'b0;
    i_rx_sh_err = 2'h2;
    @(negedge i_clk);
    chk(o_rx_framing_err_valid, 0, "sh idle");
    chk(o_rx_framing_err, 2'h0, "sh masked");
    i_ce = 1'b0;
    i_rx_sh_err_valid = 1'b1;
    @(negedge i_clk);
    chk(o_rx_framing_err_valid, 0, "ce frozen");
    i_ce = 1'b1;
    i_rx_sh_err_valid = 1'b0;
  endtask

  task automatic t_resync();
    i_rx_force_resync = 1'b1;
    @(negedge i_clk);
    i_rx_force_resync = 1'b0;
    chk(o_rx_block_lock, 0, "resync");
    @(negedge i_clk);
    chk(o_tx_local_fault, 1, "tx reinit");
  endtask

  task automatic t_ilf();
    i_rx_ber_high = 1'b1;
    repeat (2) @(negedge i_clk);
    chk(o_rx_internal_local_fault, 1, "ilf ber");
    chk(o_rx_error_rate_high, 1, "ber");
    chk(o_rx_local_fault, 1, "lf or");
    i_rx_ber_high = 1'b0;
    i_rx_test_pattern = 1'b1;
    repeat (2) @(negedge i_clk);
    chk(o_rx_internal_local_fault, 1, "ilf tp");
    chk(o_rx_error_rate_high, 0, "ber off");
    i_rx_test_pattern = 1'b0;
    repeat (2) @(negedge i_clk);
    chk(o_rx_internal_local_fault, 0, "ilf off");
    chk(o_rx_local_fault, 0, "lf off");
  endtask

  task automatic t_flt();
    cols(4, 1'b1, 1'b0);
    chk(o_rx_received_local_fault, 0, "lf ignored");
    cols(4, 1'b0, 1'b1);
    chk(o_rx_remote_fault, 1, "rf");
    cols(128, 1'b0, 1'b0);
    chk(o_rx_remote_fault, 0, "rf clear");
    i_rx_process_lfi = 1'b1;
    cols(3, 1'b1, 1'b0);
    chk(o_rx_received_local_fault, 0, "lf three");
    cols(1, 1'b1, 1'b0);
    chk(o_rx_received_local_fault, 1, "lf four");
    chk(o_rx_local_fault, 1, "lf or rx");
  endtask

  initial begin
    repeat (16) @(negedge i_clk);
    i_reset = 1'b0;
    @(negedge i_clk);
    t_lock();
    t_tx();
    t_fcs();
    t_len();
    t_pre();
    t_dis();
    t_strip();
    t_sh();
    t_resync();
    t_ilf();
    t_flt();
    final_report();
  end
endmodule
`default_nettype wire
